// ### design/pci_bridge_map.svh
`ifndef PCI_BRIDGE_MAP_SVH
`define PCI_BRIDGE_MAP_SVH

// register byte offsets
`define OFS_IO_BASE_LO      16'hD198
`define OFS_IO_BASE_HI      16'hD19C
`define OFS_CFG_ADDR        16'hD1A0
`define OFS_CFG_DATA        16'hD1A4
`define OFS_CFG_STATUS      16'hD1B0

// io window register, positions within the 64-bit value
`define IOW_VALID_BIT       38
`define IOW_SWAPDIS_BIT     37
`define IOW_CONVERT_BIT     36
`define IOW_BASE_MSB        35
`define IOW_BASE_LSB        8
`define IOW_HI_BASE_MSB     3
`define IOW_HI_BASE_LSB     0
`define IOW_HI_CONVERT      4
`define IOW_HI_SWAPDIS      5
`define IOW_HI_VALID        6

// io window reset values
`define IOW_VALID_RST       1'h0
`define IOW_SWAPDIS_LE      1'h1
`define IOW_SWAPDIS_BE      1'h0
`define IOW_CONVERT_LE      1'h0
`define IOW_CONVERT_BE      1'h1

// configuration address register fields
`define CFA_BUS_MSB         23
`define CFA_BUS_LSB         16
`define CFA_DEV_MSB         15
`define CFA_DEV_LSB         11
`define CFA_FN_MSB          10
`define CFA_FN_LSB          8
`define CFA_DW_MSB          7
`define CFA_DW_LSB          2
`define CFA_TYPE_MSB        1
`define CFA_TYPE_LSB        0
`define CFA_TYPE0           2'h0
`define CFA_TYPE1           2'h1
`define CFA_IDSEL_BASE      6'h0B

// status register bits
`define STS_BUSY_BIT        0
`define STS_DONE_BIT        1

// pci io bar in the configuration header: 256-byte window
`define BAR_ADDR_LSB        8
`define BAR_IO_FLAG         32'h0000_0001

`endif

// ### design/pci_bridge_pkg.sv
package pci_bridge_pkg;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } access_size_t;

    typedef enum logic [2:0] {
        CFG_IDLE = 3'b001,
        CFG_WAIT = 3'b010,
        CFG_DONE = 3'b100
    } cfg_state_t;

endpackage : pci_bridge_pkg

// ### design/lane_steer.sv
`timescale 1ns/1ps
`default_nettype none

// byte steering for io window data: optional full reversal of the
// dword, and optional endian conversion of the lane enables
module lane_steer #(
    parameter int LANES = 4
) (
    input  wire logic [LANES*8-1:0] dataIn,
    input  wire logic [LANES-1:0]   laneEnIn,
    input  wire logic               swapOn,
    input  wire logic               convertOn,
    output logic      [LANES*8-1:0] dataOut,
    output logic      [LANES-1:0]   laneEnOut
);

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            dataOut[i*8 +: 8] = swapOn ? dataIn[(LANES-1-i)*8 +: 8]
                                       : dataIn[i*8 +: 8];
            laneEnOut[i]      = convertOn ? laneEnIn[LANES-1-i]
                                          : laneEnIn[i];
        end
    end

endmodule // lane_steer

`default_nettype wire

// ### design/pci_io_window_and_config_access.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pci_bridge_map.svh"

module pci_io_window_and_config_access #(
    parameter int ADDR_W = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       bigEndianStrap,
    input  wire logic [ADDR_W-1:0]          regAddr,
    input  wire logic [31:0]                regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    input  wire pci_bridge_pkg::access_size_t regSize,
    output logic      [31:0]                regRdata,
    output logic                            cfgReq,
    output logic                            cfgWrite,
    output logic      [31:0]                cfgAddr,
    output logic      [3:0]                 cfgByteEn,
    output logic      [31:0]                cfgWdata,
    input  wire logic                       cfgAck,
    input  wire logic [31:0]                cfgRdata,
    input  wire logic                       hdrBarWrite,
    input  wire logic [31:0]                hdrBarWdata,
    output logic      [31:0]                hdrBarRdata,
    input  wire logic                       tgtIoValid,
    input  wire logic                       tgtIoWrite,
    input  wire logic [31:0]                tgtIoAddr,
    input  wire logic [3:0]                 tgtIoByteEn,
    input  wire logic [31:0]                tgtIoWdata,
    output logic      [31:0]                tgtIoRdata,
    output logic                            tgtIoRdataValid,
    output logic                            sysIoValid,
    output logic                            sysIoWrite,
    output logic      [35:0]                sysIoAddr,
    output logic      [3:0]                 sysIoByteEn,
    output logic      [31:0]                sysIoWdata,
    input  wire logic [31:0]                sysIoRdata,
    input  wire logic                       sysIoRdataValid
);
    import pci_bridge_pkg::*;

    logic                 ioValid_r;
    logic                 swapDisable_r;
    logic                 endianConvert_r;
    logic [35:8]          ioBase_r;
    logic                 strapDone_r;
    logic                 bigEndian_r;
    logic [7:0]           busIndex_r;
    logic [4:0]           devIndex_r;
    logic [2:0]           fnIndex_r;
    logic [5:0]           dwordIndex_r;
    logic [1:0]           cycleType_r;
    logic [31:0]          cfgDataWord_r;
    logic [1:0]           pendLane_r;
    access_size_t         pendSize_r;
    logic                 readDone_r;
    cfg_state_t           cfgState_r;
    logic [31:8]          barBase_r;
    logic [31:0]          barRead;
    logic [31:0]          rdata_nxt;
    logic [1:0]           lane;
    logic [3:0]           laneEn;
    logic [31:0]          upperAddr;
    logic [63:0]          idselWide;
    logic                 selLo;
    logic                 selHi;
    logic                 selAdr;
    logic                 selData;
    logic                 selSts;
    logic                 cfgIdle;
    logic                 ioHit;
    logic                 swapOn;
    logic [31:0]          fwdData;
    logic [3:0]           fwdLaneEn;
    logic [31:0]          backData;
    logic [31:0]          readShift;

    assign selLo   = (regAddr == ADDR_W'(`OFS_IO_BASE_LO));
    assign selHi   = (regAddr == ADDR_W'(`OFS_IO_BASE_HI));
    assign selAdr  = (regAddr == ADDR_W'(`OFS_CFG_ADDR));
    assign selData = (regAddr[ADDR_W-1:2] == (ADDR_W-2)'(`OFS_CFG_DATA >> 2));
    assign selSts  = (regAddr == ADDR_W'(`OFS_CFG_STATUS));
    assign cfgIdle = (cfgState_r == CFG_IDLE);

    // lane of the access inside the configuration dword
    always_comb begin
        lane   = 2'h0;
        laneEn = 4'hF;
        unique case (regSize)
            SIZE_BYTE: begin
                lane   = bigEndian_r ? ~regAddr[1:0] : regAddr[1:0];
                laneEn = 4'h1 << lane;
            end
            SIZE_HALF: begin
                lane   = bigEndian_r ? {~regAddr[1], 1'b0}
                                     : {regAddr[1], 1'b0};
                laneEn = 4'h3 << lane;
            end
            SIZE_WORD: begin
                lane   = 2'h0;
                laneEn = 4'hF;
            end
            default: begin
                lane   = 2'h0;
                laneEn = 4'h0;
            end
        endcase
    end

    // idsel decode; device values above 20 shift past ad[31] and select none
    assign idselWide = 64'h1 << (6'(devIndex_r) + `CFA_IDSEL_BASE);

    always_comb begin
        if (cycleType_r == `CFA_TYPE1) begin
            upperAddr = {8'h00, busIndex_r, devIndex_r, fnIndex_r,
                         dwordIndex_r, cycleType_r};
        end else begin
            upperAddr = {idselWide[31:11], fnIndex_r, dwordIndex_r,
                         2'h0};
        end
    end

    // strap is caught on the first edge after reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapDone_r <= 1'b0;
            bigEndian_r <= 1'b0;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'b1;
            bigEndian_r <= bigEndianStrap;
        end
    end

    // io window register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ioValid_r       <= `IOW_VALID_RST;
            swapDisable_r   <= `IOW_SWAPDIS_LE;
            endianConvert_r <= `IOW_CONVERT_LE;
            ioBase_r        <= '0;
        end else if (!strapDone_r) begin
            swapDisable_r   <= bigEndianStrap ? `IOW_SWAPDIS_BE
                                              : `IOW_SWAPDIS_LE;
            endianConvert_r <= bigEndianStrap ? `IOW_CONVERT_BE
                                              : `IOW_CONVERT_LE;
        end else if (regWrite && selLo) begin
            ioBase_r[31:8] <= regWdata[31:`IOW_BASE_LSB];
        end else if (regWrite && selHi) begin
            ioBase_r[35:32] <= regWdata[`IOW_HI_BASE_MSB:`IOW_HI_BASE_LSB];
            endianConvert_r <= regWdata[`IOW_HI_CONVERT];
            swapDisable_r   <= regWdata[`IOW_HI_SWAPDIS];
            ioValid_r       <= regWdata[`IOW_HI_VALID];
        end
    end

    // configuration address register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busIndex_r   <= '0;
            devIndex_r   <= '0;
            fnIndex_r    <= '0;
            dwordIndex_r <= '0;
            cycleType_r  <= `CFA_TYPE0;
        end else if (regWrite && selAdr) begin
            busIndex_r   <= regWdata[`CFA_BUS_MSB:`CFA_BUS_LSB];
            devIndex_r   <= regWdata[`CFA_DEV_MSB:`CFA_DEV_LSB];
            fnIndex_r    <= regWdata[`CFA_FN_MSB:`CFA_FN_LSB];
            dwordIndex_r <= regWdata[`CFA_DW_MSB:`CFA_DW_LSB];
            cycleType_r  <= regWdata[`CFA_TYPE_MSB:`CFA_TYPE_LSB];
        end
    end

    // configuration cycle engine; one cycle at a time, a port access
    // while busy is dropped rather than queued
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfgState_r <= CFG_IDLE;
            cfgReq     <= 1'b0;
            cfgWrite   <= 1'b0;
            cfgAddr    <= '0;
            cfgByteEn  <= '0;
            cfgWdata   <= '0;
            pendLane_r <= '0;
            pendSize_r <= SIZE_WORD;
        end else begin
            unique case (cfgState_r)
                CFG_IDLE: begin
                    if ((regWrite || regRead) && selData) begin
                        cfgState_r <= CFG_WAIT;
                        cfgReq     <= 1'b1;
                        cfgWrite   <= regWrite;
                        cfgAddr    <= (cycleType_r == `CFA_TYPE1)
                                      ? upperAddr
                                      : {upperAddr[31:2], lane};
                        cfgByteEn  <= laneEn;
                        cfgWdata   <= regWdata << {lane, 3'h0};
                        pendLane_r <= lane;
                        pendSize_r <= regSize;
                    end
                end
                CFG_WAIT: begin
                    if (cfgAck) begin
                        cfgState_r <= CFG_DONE;
                        cfgReq     <= 1'b0;
                    end
                end
                CFG_DONE: begin
                    cfgState_r <= CFG_IDLE;
                    cfgWrite   <= 1'b0;
                end
            endcase
        end
    end

    // read result, aligned to the low bits for the access size
    assign readShift = cfgRdata >> {pendLane_r, 3'h0};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfgDataWord_r <= '0;
            readDone_r    <= 1'b0;
        end else if (cfgState_r == CFG_WAIT && cfgAck && !cfgWrite) begin
            unique case (pendSize_r)
                SIZE_BYTE: cfgDataWord_r <= {24'h0, readShift[7:0]};
                SIZE_HALF: cfgDataWord_r <= {16'h0, readShift[15:0]};
                SIZE_WORD: cfgDataWord_r <= cfgRdata;
                default:   cfgDataWord_r <= cfgRdata;
            endcase
            readDone_r <= 1'b1;
        end else if (cfgIdle && regRead && selData) begin
            readDone_r <= 1'b0;
        end
    end

    // header io bar, only alive while the window is open
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            barBase_r <= '0;
        end else if (hdrBarWrite && ioValid_r) begin
            barBase_r <= hdrBarWdata[31:`BAR_ADDR_LSB];
        end
    end

    assign barRead = ioValid_r ? ({barBase_r, 8'h00} | `BAR_IO_FLAG)
                               : 32'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hdrBarRdata <= '0;
        end else begin
            hdrBarRdata <= barRead;
        end
    end

    // target io forwarding; swap is undone when swap-disable is set, so a
    // big-endian dword passes in its own order
    assign swapOn = ~swapDisable_r;
    assign ioHit  = ioValid_r && tgtIoValid
                    && (tgtIoAddr[31:8] == barBase_r);

    lane_steer #(
        .LANES (4)
    ) fwdSteer (
        .dataIn    (tgtIoWdata),
        .laneEnIn  (tgtIoByteEn),
        .swapOn    (swapOn),
        .convertOn (endianConvert_r),
        .dataOut   (fwdData),
        .laneEnOut (fwdLaneEn)
    );

    lane_steer #(
        .LANES (4)
    ) backSteer (
        .dataIn    (sysIoRdata),
        .laneEnIn  (4'h0),
        .swapOn    (swapOn),
        .convertOn (1'b0),
        .dataOut   (backData),
        .laneEnOut ()
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysIoValid  <= 1'b0;
            sysIoWrite  <= 1'b0;
            sysIoAddr   <= '0;
            sysIoByteEn <= '0;
            sysIoWdata  <= '0;
        end else begin
            sysIoValid <= ioHit;
            if (ioHit) begin
                sysIoWrite  <= tgtIoWrite;
                sysIoAddr   <= {ioBase_r, tgtIoAddr[7:0]};
                sysIoByteEn <= fwdLaneEn;
                sysIoWdata  <= fwdData;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tgtIoRdata      <= '0;
            tgtIoRdataValid <= 1'b0;
        end else begin
            tgtIoRdataValid <= sysIoRdataValid;
            if (sysIoRdataValid) begin
                tgtIoRdata <= backData;
            end
        end
    end

    // register read mux, answered one cycle after the strobe
    always_comb begin
        rdata_nxt = 32'h0;
        if (selLo) begin
            rdata_nxt = {ioBase_r[31:8], 8'h00};
        end else if (selHi) begin
            rdata_nxt = {25'h0, ioValid_r, swapDisable_r, endianConvert_r,
                         ioBase_r[35:32]};
        end else if (selAdr) begin
            rdata_nxt = {8'h00, busIndex_r, devIndex_r, fnIndex_r,
                         dwordIndex_r, cycleType_r};
        end else if (selData) begin
            rdata_nxt = cfgDataWord_r; // last completed read
        end else if (selSts) begin
            rdata_nxt = 32'h0;
            rdata_nxt[`STS_BUSY_BIT] = !cfgIdle;
            rdata_nxt[`STS_DONE_BIT] = readDone_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= rdata_nxt;
        end else begin
            regRdata <= '0;
        end
    end

endmodule // pci_io_window_and_config_access

`default_nettype wire

// ### test/pci_io_window_and_config_access_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pci_io_window_and_config_access_monitor #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0]       regWdata,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [31:0]       regRdata,
    input wire logic              cfgReq,
    input wire logic              cfgWrite,
    input wire logic [31:0]       cfgAddr,
    input wire logic [3:0]        cfgByteEn,
    input wire logic              cfgAck,
    input wire logic [31:0]       hdrBarRdata,
    input wire logic              tgtIoValid,
    input wire logic              tgtIoWrite,
    input wire logic [31:0]       tgtIoAddr,
    input wire logic              sysIoValid,
    input wire logic              sysIoWrite,
    input wire logic [35:0]       sysIoAddr
);
    logic winOpen_r;
    logic portHit;

    // shadow of the valid bit, so the gate can be judged from the ports
    assign portHit = (regWrite || regRead) && regAddr[15:2] == 14'h3469;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            winOpen_r <= 1'b0;
        end else if (regWrite && regAddr == 16'hD19C) begin
            winOpen_r <= regWdata[6];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_read_slot: assert property (
        !$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside its slot");
    a_launch_by_port: assert property (
        $rose(cfgReq) |-> $past(portHit) && cfgWrite == $past(regWrite))
        else $error("config cycle without data port access");
    a_req_held: assert property (
        cfgReq && !cfgAck |=> cfgReq)
        else $error("config request dropped before ack");
    a_req_ends: assert property (
        cfgReq && cfgAck |=> !cfgReq [*2])
        else $error("config request not ended by ack");
    a_fields_hold: assert property (
        cfgReq && $past(cfgReq) |-> $stable(cfgAddr) && $stable(cfgByteEn))
        else $error("config address moved during cycle");
    a_lane_shape: assert property (
        $rose(cfgReq) |-> cfgByteEn inside {4'h1, 4'h2, 4'h4, 4'h8,
                                            4'h3, 4'hC, 4'hF})
        else $error("illegal config byte enables");
    a_window_gate: assert property (
        sysIoValid |-> $past(winOpen_r) && $past(tgtIoValid))
        else $error("io forward without open window");
    a_bar_closed: assert property (
        !winOpen_r && !$past(winOpen_r) |-> hdrBarRdata == 32'h0)
        else $error("io bar visible while window closed");
    a_io_offset: assert property (
        sysIoValid |-> sysIoAddr[7:0] == 8'($past(tgtIoAddr))
                       && sysIoWrite == $past(tgtIoWrite))
        else $error("io offset or direction lost");

    c_cfg_write: cover property ($rose(cfgReq) && cfgWrite);
    c_cfg_read: cover property ($rose(cfgReq) && !cfgWrite);
    c_io_hit: cover property (sysIoValid);
endmodule // pci_io_window_and_config_access_monitor

bind pci_io_window_and_config_access pci_io_window_and_config_access_monitor
    #(.ADDR_W(ADDR_W)) i_pci_io_window_and_config_access_monitor (
    .clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .cfgReq, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgAck, .hdrBarRdata,
    .tgtIoValid, .tgtIoWrite, .tgtIoAddr, .sysIoValid, .sysIoWrite,
    .sysIoAddr);
`default_nettype wire

// ### test/pci_cfg_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module pci_cfg_target_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  delay,
    input  wire logic        cfgReq,
    input  wire logic [31:0] cfgAddr,
    output logic             cfgAck,
    output logic      [31:0] cfgRdata
);
    logic [3:0] wait_r;

    // read data toggles outside the ack cycle so stale data never matches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfgAck   <= 1'b0;
            cfgRdata <= 32'h0;
            wait_r   <= 4'h0;
        end else if (cfgReq && !cfgAck && wait_r == delay) begin
            cfgAck   <= 1'b1;
            cfgRdata <= {cfgAddr[31:2], 2'h0} ^ 32'h5A3C_96E1;
            wait_r   <= 4'h0;
        end else begin
            cfgAck   <= 1'b0;
            cfgRdata <= ~cfgRdata;
            wait_r   <= (cfgReq && !cfgAck) ? wait_r + 4'h1 : 4'h0;
        end
    end
endmodule // pci_cfg_target_model
`default_nettype wire

// ### test/test_pci_io_window_and_config_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_pci_io_window_and_config_access;
    import pci_bridge_pkg::*;
    logic         clk = 1'b0, rstn = 1'b0, bigEndianStrap = 1'b0;
    logic [15:0]  regAddr = 16'h0;
    logic [31:0]  regWdata = 32'h0, tgtIoAddr = 32'h0, tgtIoWdata = 32'h0;
    logic         regWrite = 1'b0, regRead = 1'b0, hdrBarWrite = 1'b0;
    logic         tgtIoValid = 1'b0, tgtIoWrite = 1'b0, sysIoRdataValid = 1'b0;
    logic [31:0]  hdrBarWdata = 32'h0, regRdata, cfgAddr, cfgWdata;
    logic [31:0]  cfgRdata, hdrBarRdata, sysIoWdata, tgtIoRdata, sysIoRdata;
    logic [3:0]   tgtIoByteEn = 4'h0, delay = 4'h0, cfgByteEn, sysIoByteEn;
    logic         cfgReq, cfgWrite, cfgAck, sysIoValid, sysIoWrite;
    logic [35:0]  sysIoAddr;
    logic         tgtIoRdataValid;
    access_size_t regSize = SIZE_WORD;
    int           seed = 86918, miscompares = 0, numChecks = 0;

    pci_io_window_and_config_access i_pci_io_window_and_config_access (
        .clk, .rstn, .bigEndianStrap, .regAddr, .regWdata, .regWrite,
        .regRead, .regSize, .regRdata, .cfgReq, .cfgWrite, .cfgAddr,
        .cfgByteEn, .cfgWdata, .cfgAck, .cfgRdata, .hdrBarWrite,
        .hdrBarWdata, .hdrBarRdata, .tgtIoValid, .tgtIoWrite, .tgtIoAddr,
        .tgtIoByteEn, .tgtIoWdata, .tgtIoRdata, .tgtIoRdataValid,
        .sysIoValid, .sysIoWrite, .sysIoAddr, .sysIoByteEn, .sysIoWdata,
        .sysIoRdata, .sysIoRdataValid);
    pci_cfg_target_model i_pci_cfg_target_model (
        .clk, .rstn, .delay, .cfgReq, .cfgAddr, .cfgAck, .cfgRdata);

    always #2.5 clk = ~clk;

    task automatic check(input string what, input logic [35:0] seen,
                         input logic [35:0] exp);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input access_size_t s = SIZE_WORD);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regSize  <= s;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      input access_size_t s = SIZE_WORD);
        @(posedge clk);
        regAddr <= a;
        regSize <= s;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic reset_dut(input logic big);
        @(posedge clk);
        rstn           <= 1'b0;
        bigEndianStrap <= big;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // the port is polled, never stalled, so completion shows in status
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        for (int n = 0; n < 40 && s[0] !== 1'b0; n++) begin
            rd(16'hD1B0, s);
        end
        check("engine idle", s[0], 1'b0);
    endtask

    function automatic logic [31:0] addr_of(logic [31:0] ca, logic [1:0] ln);
        logic [20:0] sel;
        sel = (ca[15:11] <= 5'd20) ? 21'h1 << ca[15:11] : 21'h0;
        return ca[0] ? {ca[31:2], ln} : {sel, ca[10:2], ln};
    endfunction

    task automatic cfg_op(input logic isWr, input access_size_t s,
                          input logic [1:0] off, input logic [31:0] ca);
        logic [1:0]  ln;
        logic [3:0]  be;
        logic [31:0] ea, am, bm, sm, wd, d;
        ln = (s == SIZE_WORD) ? 2'h0 : (s == SIZE_HALF)
           ? {off[1] ^ bigEndianStrap, 1'b0} : off ^ {2{bigEndianStrap}};
        be = (s == SIZE_WORD) ? 4'hF : (s == SIZE_HALF ? 4'h3 : 4'h1) << ln;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        sm = (s == SIZE_WORD) ? 32'hFFFF_FFFF : (s == SIZE_HALF)
           ? 32'hFFFF : 32'hFF;
        ea = addr_of(ca, ln);
        am = ca[0] ? 32'hFFFF_FFFC : 32'hFFFF_FFFF;
        wd = $random(seed);
        wr(16'hD1A0, ca);
        delay <= 4'($random(seed) & 7);
        rd(16'hD1A0, d);
        check("cfg address", d, ca);
        if (isWr) begin
            wr(16'hD1A4 + 16'(off), wd, s);
        end else begin
            rd(16'hD1A4 + 16'(off), d, s);
        end
        check("cfg request", cfgReq, 1'b1);
        check("cfg direction", cfgWrite, isWr);
        check("cfg bus address", cfgAddr & am, ea & am);
        check("cfg lanes", cfgByteEn, be);
        if (isWr) begin
            check("cfg wdata", cfgWdata & bm, (wd << 8 * ln) & bm);
        end
        wait_idle();
        if (!isWr) begin
            rd(16'hD1A4 + 16'(off), d, s);
            ea = {ea[31:2], 2'h0} ^ 32'h5A3C_96E1;
            check("cfg rdata", d, (ea >> 8 * ln) & sm);
            wait_idle();
        end
    endtask

    task automatic bar(input logic we, input logic [31:0] d,
                       input logic [31:0] exp);
        @(posedge clk);
        hdrBarWrite <= we;
        hdrBarWdata <= d;
        @(posedge clk);
        hdrBarWrite <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("io bar", hdrBarRdata, exp);
    endtask

    task automatic io(input logic [31:0] a, input logic hit,
                      input logic [1:0] k);
        logic        w;
        logic [3:0]  be;
        logic [31:0] d, x;
        w  = 1'($random(seed));
        be = 4'($random(seed));
        d  = $random(seed);
        @(posedge clk);
        tgtIoValid  <= 1'b1;
        tgtIoAddr   <= a;
        tgtIoWrite  <= w;
        tgtIoByteEn <= be;
        tgtIoWdata  <= d;
        @(posedge clk);
        tgtIoValid <= 1'b0;
        #1;
        check("io forward", sysIoValid, hit);
        if (hit) begin
            check("io address", sysIoAddr, {28'h3AB_CDEF, a[7:0]});
            check("io lanes", sysIoByteEn,
                  k[0] ? {be[0], be[1], be[2], be[3]} : be);
            x = k[1] ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
            if (w) begin
                check("io data", sysIoWdata, x);
            end
            sysIoRdataValid <= 1'b1;
            sysIoRdata <= d;
            @(posedge clk);
            sysIoRdataValid <= 1'b0;
            #1;
            check("io rvalid", tgtIoRdataValid, 1'b1);
            check("io rdata", tgtIoRdata, x);
        end
    endtask

    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d, ca;
        access_size_t s;
        for (int m = 0; m < 2; m++) begin
            reset_dut(m[0]);
            rd(16'hD19C, d);
            check("window high", d, m ? 32'h10 : 32'h20);
            rd(16'hD198, d);
            check("window low", d, 32'h0);
            rd(16'hD1A0, d);
            check("cfg address reset", d, 32'h0);
            rd(16'hD1C0, d);
            check("unmapped", d, 32'h0);
            $display("done: reset values, mode %0d", m);
            // host mode only: no add-in card accesses are made
            for (int i = 0; i < 14; i++) begin
                s = (i < 2) ? SIZE_WORD : (i < 6) ? SIZE_HALF : SIZE_BYTE;
                ca = {8'h0, 22'($random(seed)), 1'b0, 1'($random(seed))};
                if (i < 2) begin
                    ca[15:11] = 5'd20 + 5'(i);
                    ca[0] = 1'b0;
                end
                cfg_op(i[0], s, (i < 2) ? 2'h0 : (i < 6)
                       ? {i[2], 1'b0} : 2'(i - 6), ca);
            end
            $display("done: config cycles, mode %0d", m);
        end
        bar(1'b1, 32'h5600, 32'h0);
        wr(16'hD198, 32'hABCD_EF00);
        for (int k = 0; k < 4; k++) begin
            wr(16'hD19C, 32'h43 | (32'(k) << 4));
            if (k == 0) begin
                bar(1'b0, 32'h0, 32'h1);
                bar(1'b1, 32'h5600, 32'h5601);
            end
            io(32'h5600 | 32'($random(seed) & 8'hFF), 1'b1, 2'(k));
            io(32'h5734, 1'b0, 2'(k));
        end
        wr(16'hD19C, 32'h23);
        io(32'h5611, 1'b0, 2'h2);
        bar(1'b0, 32'h0, 32'h0);
        $display("done: io window");
        report_and_stop();
    end
endmodule // test_pci_io_window_and_config_access
`default_nettype wire
